/* adc_ctrl_defines.vh */
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Register offsets on the plain register port
`define ADDR_CONTROL_PRIMARY   4'h0
`define ADDR_CONTROL_SECONDARY 4'h1
`define ADDR_RESULT_LOW        4'h2
`define ADDR_RESULT_HIGH       4'h3
`define ADDR_PIN_ANALOG_SELECT 4'h4
`define ADDR_PIN_PULL_HIGH     4'h5

// Primary control fields
`define BIT_START        7
`define BIT_BUSY         6
`define BIT_ENABLE       5
`define BIT_ALIGN        4
`define CHANNEL_MSB      3
`define CHANNEL_LSB      0

// Secondary control fields
`define SOURCE_MSB       7
`define SOURCE_LSB       5
`define REFSEL_MSB       4
`define REFSEL_LSB       3
`define CLKSEL_MSB       2
`define CLKSEL_LSB       0

// Source field codes
`define SOURCE_EXTERNAL  3'h0
`define SOURCE_BANDGAP   3'h1

// Reset values
`define RESET_PRIMARY    8'h00
`define RESET_SECONDARY  8'h00
`define RESET_PIN_SELECT 8'h00
`define RESET_PULL_HIGH  8'h00

// Conversion timing: converter clock periods per result
`define CONVERT_PERIODS  5'd16

`endif

/* adc_control_and_result_regs.v */
`timescale 1ns/100ps
`include "adc_ctrl_defines.vh"

// Summary of operation
// - Converter yields 12-bit result, external or bandgap
// - Eight external inputs, chosen by channel field
// - Source field picks bandgap or external channel
// - Single converter behind one selection multiplexer
// - Result held in read-only high/low bytes
// - Alignment bit sets placement of result bits
// - Unused result bit positions read zero
// - Disabled converter leaves result untouched
// - Control register field positions as documented
// - Analog-selected pin loses its digital function
// - Analog-selected pin loses its pull-high resistor
module adc_control_and_result_regs (
    input  wire        clock,
    input  wire        reset,
    input  wire        clock_enable,
    input  wire [3:0]  address,
    input  wire [7:0]  write_data,
    input  wire        write_strobe,
    input  wire        read_strobe,
    output reg  [7:0]  read_data,
    output reg  [3:0]  mux_select,
    output reg         mux_use_bandgap,
    output reg         mux_source_valid,
    output reg         converter_power,
    output reg  [1:0]  reference_select,
    output reg         sample_strobe,
    input  wire [11:0] converter_data,
    output reg         conversion_busy_flag,
    output reg  [7:0]  pin_digital_enable,
    output reg  [7:0]  pin_pull_high_enable
);

    localparam IDLE    = 2'd0;
    localparam CONVERT = 2'd1;
    localparam CAPTURE = 2'd2;

    reg [1:0]  state;
    reg [3:0]  external_channel_field;
    reg        converter_enable_bit;
    reg        result_alignment_bit;
    reg [2:0]  input_source_field;
    reg [2:0]  conversion_clock_field;
    reg [11:0] result;
    reg [7:0]  pin_analog_select;
    reg [7:0]  pin_pull_high_setting;
    reg [7:0]  prescale;
    reg [4:0]  period_count;
    reg        start_request;
    reg [7:0]  result_low_byte;
    reg [7:0]  result_high_byte;
    reg [7:0]  control_reg_primary;
    reg [7:0]  control_reg_secondary;
    wire       write_primary;
    wire       converter_tick;

    // Prescaler tap chosen by the clock field: divide by 2^(field+1)
    function tap;
        input [7:0] count;
        input [2:0] sel;
        integer k;
        begin
            tap = 1'b1;
            // A variable part-select is not legal, so mask bit by bit
            for (k = 0; k < 8; k = k + 1) begin
                if (k <= sel)
                    tap = tap & count[k];
            end
        end
    endfunction

    assign write_primary  = write_strobe &&
                            (address == `ADDR_CONTROL_PRIMARY);
    assign converter_tick = tap(prescale, conversion_clock_field);

    // Result byte views, unused positions forced low
    always @* begin
        if (result_alignment_bit) begin
            result_high_byte = {4'h0, result[11:8]};
            result_low_byte  = result[7:0];
        end else begin
            result_high_byte = result[11:4];
            result_low_byte  = {result[3:0], 4'h0};
        end
        control_reg_primary = {1'b0, conversion_busy_flag,
                               converter_enable_bit, result_alignment_bit,
                               external_channel_field};
        control_reg_secondary = {input_source_field, reference_select,
                                 conversion_clock_field};
    end

    // Source multiplexer drive for the one shared converter
    always @* begin
        mux_select       = external_channel_field;
        mux_use_bandgap  = (input_source_field == `SOURCE_BANDGAP);
        // Channel codes 8..15 have no pin; the mux stays open for them
        mux_source_valid = mux_use_bandgap ||
                           ((input_source_field == `SOURCE_EXTERNAL) &&
                            !external_channel_field[3]);
        converter_power  = converter_enable_bit;
    end

    // Pin takeover: analog selection overrides digital and pull-high
    always @* begin
        pin_digital_enable   = ~pin_analog_select;
        pin_pull_high_enable = pin_pull_high_setting &
                               ~pin_analog_select;
    end

    // Register writes; start is a self-clearing request
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            external_channel_field <= 4'h0;
            converter_enable_bit   <= 1'b0;
            result_alignment_bit   <= 1'b0;
            input_source_field     <= 3'h0;
            reference_select       <= 2'h0;
            conversion_clock_field <= 3'h0;
            pin_analog_select      <= `RESET_PIN_SELECT;
            pin_pull_high_setting  <= `RESET_PULL_HIGH;
            start_request          <= 1'b0;
        end else if (clock_enable) begin
            start_request <= 1'b0;
            if (write_primary) begin
                start_request <= write_data[`BIT_START];
                converter_enable_bit   <= write_data[`BIT_ENABLE];
                result_alignment_bit   <= write_data[`BIT_ALIGN];
                external_channel_field <=
                    write_data[`CHANNEL_MSB:`CHANNEL_LSB];
            end
            if (write_strobe && address == `ADDR_CONTROL_SECONDARY) begin
                input_source_field <= write_data[`SOURCE_MSB:`SOURCE_LSB];
                reference_select   <= write_data[`REFSEL_MSB:`REFSEL_LSB];
                conversion_clock_field <=
                    write_data[`CLKSEL_MSB:`CLKSEL_LSB];
            end
            // Software configures the pin before choosing the channel
            if (write_strobe && address == `ADDR_PIN_ANALOG_SELECT)
                pin_analog_select <= write_data;
            if (write_strobe && address == `ADDR_PIN_PULL_HIGH)
                pin_pull_high_setting <= write_data;
        end
    end

    // Conversion sequencer
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state                <= IDLE;
            conversion_busy_flag <= 1'b0;
            result               <= 12'h000;
            prescale             <= 8'h00;
            period_count         <= 5'd0;
            sample_strobe        <= 1'b0;
        end else if (clock_enable) begin
            sample_strobe <= 1'b0;
            prescale      <= prescale + 8'h01;
            case (state)
            IDLE: begin
                if (start_request && converter_enable_bit) begin
                    state                <= CONVERT;
                    conversion_busy_flag <= 1'b1;
                    period_count         <= 5'd0;
                    prescale             <= 8'h00;
                end
            end
            CONVERT: begin
                // Disabling mid-conversion aborts and keeps the old result
                if (!converter_enable_bit) begin
                    state                <= IDLE;
                    conversion_busy_flag <= 1'b0;
                end else if (converter_tick) begin
                    if (period_count == `CONVERT_PERIODS - 5'd1) begin
                        state         <= CAPTURE;
                        sample_strobe <= 1'b1;
                    end else begin
                        period_count <= period_count + 5'd1;
                    end
                end
            end
            CAPTURE: begin
                if (converter_enable_bit)
                    result <= converter_data;
                conversion_busy_flag <= 1'b0;
                state                <= IDLE;
            end
            default: begin
                state                <= IDLE;
                conversion_busy_flag <= 1'b0;
            end
            endcase
        end
    end

    // Read port: data stand one cycle after the strobe
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (clock_enable) begin
            read_data <= 8'h00;
            if (read_strobe) begin
                case (address)
                `ADDR_CONTROL_PRIMARY:   read_data <= control_reg_primary;
                `ADDR_CONTROL_SECONDARY: read_data <= control_reg_secondary;
                `ADDR_RESULT_LOW:        read_data <= result_low_byte;
                `ADDR_RESULT_HIGH:       read_data <= result_high_byte;
                `ADDR_PIN_ANALOG_SELECT: read_data <= pin_analog_select;
                `ADDR_PIN_PULL_HIGH:     read_data <= pin_pull_high_setting;
                default:                 read_data <= 8'h00;
                endcase
            end
        end
    end

endmodule // adc_control_and_result_regs

/* adc_control_and_result_regs_assertions.sv */
`timescale 1ns/100ps
module adc_control_and_result_regs_assertions (
    input wire       clock,
    input wire       reset,
    input wire       clock_enable,
    input wire [3:0] address,
    input wire [7:0] write_data,
    input wire       write_strobe,
    input wire       read_strobe,
    input wire [7:0] read_data,
    input wire       mux_use_bandgap,
    input wire       mux_source_valid,
    input wire       converter_power,
    input wire       sample_strobe,
    input wire       conversion_busy_flag,
    input wire [7:0] pin_digital_enable,
    input wire [7:0] pin_pull_high_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // A start while busy is ignored except in the CAPTURE cycle or the abort cycle after a disable, so only an idle start is checked
    wire start = clock_enable && write_strobe && address == 4'h0
        && write_data[7] && write_data[5] && !conversion_busy_flag;
    a_pull_off: assert property
        ((pin_pull_high_enable & ~pin_digital_enable) == 8'h00)
        else $error("pull-high on analog pin");
    a_busy_rise: assert property (start |-> ##2 conversion_busy_flag)
        else $error("busy not raised");
    a_sample_on: assert property
        (sample_strobe |-> conversion_busy_flag && converter_power)
        else $error("sample while idle or off");
    a_sample_pulse: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe too long");
    a_busy_ends: assert property
        (sample_strobe && clock_enable |-> ##[1:2] !conversion_busy_flag)
        else $error("busy not cleared");
    a_abort_idle: assert property
        (!converter_power [*2] |-> !conversion_busy_flag)
        else $error("busy while disabled");
    a_idle_read: assert property
        (clock_enable && !read_strobe |=> read_data == 8'h00)
        else $error("read data not zero");
    a_busy_bit: assert property (clock_enable && read_strobe
        && address == 4'h0 |=> read_data[7:6] == {1'b0,
        $past(conversion_busy_flag)}) else $error("start or busy bit");
    a_mux_valid: assert property
        (mux_use_bandgap |-> mux_source_valid) else $error("bandgap invalid");
    c_start: cover property (start);
    c_sample: cover property (sample_strobe);
    c_result: cover property (read_strobe && address == 4'h3);
endmodule // adc_control_and_result_regs_assertions

bind adc_control_and_result_regs adc_control_and_result_regs_assertions
    i_checker (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .mux_use_bandgap(mux_use_bandgap),
    .mux_source_valid(mux_source_valid),
    .converter_power(converter_power), .sample_strobe(sample_strobe),
    .conversion_busy_flag(conversion_busy_flag),
    .pin_digital_enable(pin_digital_enable),
    .pin_pull_high_enable(pin_pull_high_enable));

/* analog_far_side.sv */
`timescale 1ns/100ps
module analog_far_side (
    input wire        clock,
    input wire        sample_strobe,
    input wire [11:0] level,
    output wire [11:0] converter_data
);
    reg [11:0] churn;
    initial churn = 12'h000;
    always @(posedge clock)
        churn <= ~churn;
    // Level stands only with the strobe, so an early or late capture fails
    assign converter_data = sample_strobe ? level : churn;
endmodule // analog_far_side

/* adc_control_and_result_regs_tb_top.sv */
`timescale 1ns/100ps
module adc_control_and_result_regs_tb_top;
    reg         clock = 1'b0;
    reg         reset = 1'b1;
    reg         clock_enable = 1'b1;
    reg  [3:0]  address = 4'h0;
    reg  [7:0]  write_data = 8'h00;
    reg         write_strobe = 1'b0;
    reg         read_strobe = 1'b0;
    reg  [11:0] level = 12'h000;
    reg  [31:0] seed = 32'he7ae;
    wire [7:0]  read_data;
    wire [3:0]  mux_select;
    wire        mux_use_bandgap;
    wire        sample_strobe;
    wire        conversion_busy_flag;
    wire [11:0] converter_data;
    wire [1:0]  reference_select;
    wire [7:0]  pin_digital_enable;
    wire [7:0]  pin_pull_high_enable;
    reg  [7:0]  q[$];
    reg         pend = 1'b0;
    integer     n_fail = 0;
    integer     check_count = 0;
    integer     i;
    integer     n;
    reg  [11:0] v;
    reg  [7:0]  c1;
    always #12.5 clock = ~clock;
    adc_control_and_result_regs i_adc_control_and_result_regs (
        .clock(clock), .reset(reset), .clock_enable(clock_enable),
        .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .mux_select(mux_select),
        .mux_use_bandgap(mux_use_bandgap), .mux_source_valid(),
        .converter_power(), .reference_select(reference_select),
        .sample_strobe(sample_strobe), .converter_data(converter_data),
        .conversion_busy_flag(conversion_busy_flag),
        .pin_digital_enable(pin_digital_enable),
        .pin_pull_high_enable(pin_pull_high_enable));
    analog_far_side i_analog_far_side (.clock(clock),
        .sample_strobe(sample_strobe), .level(level),
        .converter_data(converter_data));
    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        q.push_back(e);
        @(posedge clock);
        read_strobe <= 1'b0;
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wait_idle;
        for (n = 0; n < 9000 && conversion_busy_flag !== 1'b0; n = n + 1)
            @(posedge clock);
        if (n >= 9000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    endtask
    always @(posedge clock) begin
        if (pend)
            chk(read_data, q.pop_front());
        pend <= read_strobe;
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rd(i[3:0], 8'h00);
        rd(4'hf, 8'h00);
        wr(4'h5, 8'hff);
        for (i = 0; i < 9; i = i + 1) begin
            seed = nx(seed);
            v = seed[11:0];
            c1 = {(i == 8) ? 3'h1 : 3'h0, seed[17:16], 1'b0, seed[13:12]};
            wr(4'h4, 8'h01 << i);
            wr(4'h1, c1);
            level <= v;
            wr(4'h0, {3'h5, i[0], i[3:0]});
            rd(4'h1, c1);
            rd(4'h0, {3'h3, i[0], i[3:0]});
            chk({4'h0, mux_select}, {4'h0, i[3:0]});
            chk({reference_select, 5'h00, mux_use_bandgap},
                {c1[4:3], 5'h00, i == 8});
            chk(pin_digital_enable, ~(8'h01 << i));
            chk(pin_pull_high_enable, ~(8'h01 << i));
            wait_idle;
            rd(4'h2, i[0] ? v[7:0] : {v[3:0], 4'h0});
            rd(4'h3, i[0] ? {4'h0, v[11:8]} : v[11:4]);
        end
        // Abort mid-conversion, then a start while off must do nothing
        wr(4'h0, 8'ha0);
        wr(4'h0, 8'h00);
        level <= ~v;
        wr(4'h0, 8'h80);
        rd(4'h3, v[11:4]);
        rd(4'h2, {v[3:0], 4'h0});
        // A frozen block must ignore a start write
        clock_enable <= 1'b0;
        wr(4'h0, 8'ha0);
        clock_enable <= 1'b1;
        rd(4'h0, 8'h00);
        repeat (2) @(posedge clock);
        end_of_test;
    end
endmodule // adc_control_and_result_regs_tb_top
